// file: core/fls_lock_nvm_seq.sv
// Lock-bit and configuration-bit command sequencer with AXI4-Lite registers
//
// Notes on behaviour
// - Clear-lock with a page number clears the lock bit of that page's region.
// - Clear-lock completion raises ready; interrupt follows when ready enable is set.
// - Clear-lock naming a region beyond the implemented lock bits changes nothing.
// - A bad keyword sets the command error flag and performs nothing.
// - Erase or program requests to an unlocked region are granted.
// - Get-lock ignores the argument and prepares lock status for result reads.
// - Result reads past the last implemented word return zero.
// - Bit n of the lock words is region n; one means locked.
// - Array reads stay allowed while a lock command runs.
// - Configuration bits live apart from the array and never touch it.
// - Set-config sets the named bit, then raises ready and optional interrupt.
// - Set or clear config beyond the implemented bits has no effect.
// - Get-config reports the configuration bits through the result register.
// - Clear-config clears the named configuration bit.
// - Clear-config completion raises ready and the optional interrupt.
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module fls_lock_nvm_seq (
    input  wire logic                               aclk,
    input  wire logic                               aresetn,
    input  wire logic [fls_pkg::ADDR_W-1:0]         awaddr,
    input  wire logic [2:0]                         awprot,
    input  wire logic                               awvalid,
    output logic                                    awready,
    input  wire logic [fls_pkg::DATA_W-1:0]         wdata,
    input  wire logic [3:0]                         wstrb,
    input  wire logic                               wvalid,
    output logic                                    wready,
    output logic [1:0]                              bresp,
    output logic                                    bvalid,
    input  wire logic                               bready,
    input  wire logic [fls_pkg::ADDR_W-1:0]         araddr,
    input  wire logic [2:0]                         arprot,
    input  wire logic                               arvalid,
    output logic                                    arready,
    output logic [fls_pkg::DATA_W-1:0]              rdata,
    output logic [1:0]                              rresp,
    output logic                                    rvalid,
    input  wire logic                               rready,
    output logic                                    irq,
    input  wire logic                               prog_req,
    input  wire logic [15:0]                        prog_page,
    output logic                                    prog_grant,
    output logic                                    array_read_enable,
    output logic [fls_pkg::NUM_LOCK_BITS-1:0]       lock_state,
    output logic [fls_pkg::NUM_CFG_BITS-1:0]        config_bits
);
    import fls_pkg::*;

    function automatic logic fits(input logic [15:0] idx, input int limit);
        fits = int'(idx) < limit;
    endfunction

    function automatic logic known_code(input logic [7:0] code);
        known_code = (code == CODE_CLR_LOCK) || (code == CODE_GET_LOCK) ||
                     (code == CODE_SET_CFG)  || (code == CODE_CLR_CFG)  ||
                     (code == CODE_GET_CFG)  || (code == CODE_SET_LOCK);
    endfunction

    // Write channel holding
    logic                aw_held;
    logic                w_held;
    logic [ADDR_W-1:0]   aw_addr_q;
    logic [DATA_W-1:0]   w_data_q;
    logic [3:0]          w_strb_q;

    // Sequencer state
    fls_state_t          state;
    logic [CNT_W-1:0]    cnt;
    logic [7:0]          op_code;
    logic [15:0]         op_arg;
    fls_res_t            res_sel;
    logic [IDX_W-1:0]    res_idx;
    logic                cmd_error;
    fls_ev_t             ev_status;
    fls_ev_t             mode;

    wire                 aw_fire = awvalid && awready;
    wire                 w_fire  = wvalid && wready;
    wire                 wr_go   = aw_held && w_held && !bvalid;
    wire                 rd_go   = arvalid && arready;

    wire                 wr_mode   = wr_go && (aw_addr_q == OFF_MODE);
    wire                 wr_cmd    = wr_go && (aw_addr_q == OFF_CMD);
    wire                 wr_irq    = wr_go && (aw_addr_q == OFF_IRQ_STATUS);
    wire                 wr_mapped = (aw_addr_q == OFF_MODE) || (aw_addr_q == OFF_CMD) ||
                                     (aw_addr_q == OFF_STATUS) || (aw_addr_q == OFF_RESULT) ||
                                     (aw_addr_q == OFF_IRQ_STATUS);

    wire                 rd_mode   = araddr == OFF_MODE;
    wire                 rd_cmd    = araddr == OFF_CMD;
    wire                 rd_status = araddr == OFF_STATUS;
    wire                 rd_result = araddr == OFF_RESULT;
    wire                 rd_irq    = araddr == OFF_IRQ_STATUS;
    wire                 rd_mapped = rd_mode || rd_cmd || rd_status || rd_result || rd_irq;
    wire                 pop_result = rd_go && rd_result;

    wire                 command_ready_flag = state == ST_IDLE;
    fls_cmd_t            cmd_word;
    assign cmd_word = fls_cmd_t'(w_data_q);

    // A partial-strobe command write is dropped rather than half-decoded
    wire                 cmd_wr     = wr_cmd && (w_strb_q == STRB_ALL) && command_ready_flag;
    wire                 cmd_good   = (cmd_word.key == CMD_KEY) && known_code(cmd_word.code);
    wire                 cmd_accept = cmd_wr && cmd_good;
    wire                 cmd_bad    = cmd_wr && !cmd_good;
    wire                 op_done    = (state == ST_RUN) && (cnt == '0);

    wire [11:0]          op_region  = op_arg[15:REGION_SHIFT];
    wire                 region_ok  = fits({4'h0, op_region}, NUM_LOCK_BITS);
    wire                 cfg_ok     = fits(op_arg, NUM_CFG_BITS);
    wire [11:0]          prog_region = prog_page[15:REGION_SHIFT];
    wire                 lock_op    = (op_code == CODE_CLR_LOCK) || (op_code == CODE_SET_LOCK) ||
                                      (op_code == CODE_GET_LOCK);

    // Unlocked regions accept erase or program
    assign prog_grant = prog_req && fits({4'h0, prog_region}, NUM_LOCK_BITS) &&
                        !lock_state[prog_region[LOCK_IDX_W-1:0]];
    // Config-bit commands hold array reads off; lock commands do not
    assign array_read_enable = command_ready_flag || lock_op;
    assign irq = |(ev_status & mode);

    assign awready = !aw_held && !bvalid;
    assign wready  = !w_held && !bvalid;
    assign arready = !rvalid;

    logic [DATA_W-1:0] result_word;
    always_comb begin
        result_word = '0;
        for (int w = 0; w < LOCK_WORDS; w++) begin
            if (res_sel == RES_LOCK && res_idx == IDX_W'(w)) begin
                result_word = lock_state[w*DATA_W +: DATA_W];
            end
        end
        if (res_sel == RES_CFG && res_idx == '0) begin
            result_word = {{(DATA_W-NUM_CFG_BITS){1'b0}}, config_bits};
        end
    end

    wire [DATA_W-1:0] rd_word =
        rd_mode   ? {{(DATA_W-EV_W){1'b0}}, mode} :
        rd_status ? {{(DATA_W-EV_W){1'b0}}, cmd_error, command_ready_flag} :
        rd_result ? result_word :
        rd_irq    ? {{(DATA_W-EV_W){1'b0}}, ev_status} : '0;

    wire fls_ev_t ev_set = '{err: cmd_bad, done: op_done};
    wire fls_ev_t ev_clr = (wr_irq && w_strb_q[0]) ? fls_ev_t'(w_data_q[EV_W-1:0]) : '0;
    wire fls_ev_t next_ev_status = (ev_status & ~ev_clr) | ev_set;

    // AXI write side
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= '0;
            w_strb_q  <= '0;
            bvalid    <= 1'b0;
            bresp     <= RESP_OKAY;
        end else begin
            if (aw_fire) begin
                aw_held   <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (w_fire) begin
                w_held   <= 1'b1;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // AXI read side
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= '0;
            rresp  <= RESP_OKAY;
        end else if (rd_go) begin
            rvalid <= 1'b1;
            rdata  <= rd_word;
            rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    // Mode, error flag and event status
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode      <= '0;
            ev_status <= '0;
            cmd_error <= 1'b0;
        end else begin
            if (wr_mode && w_strb_q[0]) begin
                mode <= fls_ev_t'(w_data_q[EV_W-1:0]);
            end
            ev_status <= next_ev_status; // Set beats a same-cycle clear
            if (cmd_bad) begin
                cmd_error <= 1'b1;
            end else if (cmd_accept) begin
                cmd_error <= 1'b0;
            end
        end
    end

    // Command sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state   <= ST_IDLE;
            cnt     <= '0;
            op_code <= '0;
            op_arg  <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (cmd_accept) begin
                        state   <= ST_RUN;
                        cnt     <= CNT_W'(OP_CYCLES - 1);
                        op_code <= cmd_word.code;
                        op_arg  <= cmd_word.arg;
                    end
                end
                ST_RUN: begin
                    if (op_done) begin
                        state <= ST_IDLE;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Lock and configuration storage; config bits are a separate register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lock_state  <= LOCK_RESET;
            config_bits <= CFG_RESET;
        end else if (op_done) begin
            if (op_code == CODE_CLR_LOCK && region_ok) begin
                lock_state[op_region[LOCK_IDX_W-1:0]] <= 1'b0;
            end
            if (op_code == CODE_SET_LOCK && region_ok) begin
                lock_state[op_region[LOCK_IDX_W-1:0]] <= 1'b1;
            end
            if (op_code == CODE_SET_CFG && cfg_ok) begin
                config_bits[op_arg[CFG_IDX_W-1:0]] <= 1'b1;
            end
            if (op_code == CODE_CLR_CFG && cfg_ok) begin
                config_bits[op_arg[CFG_IDX_W-1:0]] <= 1'b0;
            end
        end
    end

    // Result readout pointer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            res_sel <= RES_NONE;
            res_idx <= '0;
        end else if (cmd_accept) begin
            res_sel <= RES_NONE;
            res_idx <= '0;
        end else if (op_done && op_code == CODE_GET_LOCK) begin
            res_sel <= RES_LOCK;
            res_idx <= '0;
        end else if (op_done && op_code == CODE_GET_CFG) begin
            res_sel <= RES_CFG;
            res_idx <= '0;
        end else if (pop_result && res_idx < IDX_W'(LOCK_WORDS)) begin
            res_idx <= res_idx + 1'b1;
        end
    end

    // Checks
    localparam int A_OP_MAX = 32;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_busy_low;
        cmd_accept |=> !command_ready_flag until op_done;
    endproperty
    a_busy_low: assert property (p_busy_low) else $error("ready high during operation");

    property p_done_bound;
        cmd_accept |-> ##[1:A_OP_MAX] op_done ##1 command_ready_flag;
    endproperty
    a_done_bound: assert property (p_done_bound) else $error("command never completed");

    property p_ready_irq;
        op_done && mode.done |=> irq && ev_status.done;
    endproperty
    a_ready_irq: assert property (p_ready_irq) else $error("no interrupt at completion");

    property p_bad_key;
        cmd_bad |=> cmd_error && command_ready_flag && $stable(lock_state) && $stable(config_bits);
    endproperty
    a_bad_key: assert property (p_bad_key) else $error("bad keyword not flagged");

    property p_clr_lock;
        op_done && op_code == CODE_CLR_LOCK && region_ok
            |=> !lock_state[$past(op_region[LOCK_IDX_W-1:0])];
    endproperty
    a_clr_lock: assert property (p_clr_lock) else $error("lock bit not cleared");

    property p_lock_oob;
        op_done && op_code == CODE_CLR_LOCK && !region_ok |=> $stable(lock_state);
    endproperty
    a_lock_oob: assert property (p_lock_oob) else $error("out-of-range clear changed locks");

    property p_grant;
        prog_req && prog_region < 12'(NUM_LOCK_BITS) && !lock_state[prog_region[LOCK_IDX_W-1:0]]
            |-> prog_grant;
    endproperty
    a_grant: assert property (p_grant) else $error("unlocked region refused");

    property p_read_allowed;
        (state == ST_RUN) && lock_op |-> array_read_enable;
    endproperty
    a_read_allowed: assert property (p_read_allowed) else $error("array read blocked");

    property p_first_word;
        pop_result && res_sel == RES_LOCK && res_idx == '0 |=> rdata == $past(lock_state[31:0]);
    endproperty
    a_first_word: assert property (p_first_word) else $error("wrong first lock word");

    property p_result_zero;
        pop_result && res_sel == RES_LOCK && res_idx >= IDX_W'(LOCK_WORDS) |=> rdata == '0;
    endproperty
    a_result_zero: assert property (p_result_zero) else $error("extra read not zero");

    property p_cfg_set;
        op_done && op_code == CODE_SET_CFG && cfg_ok |=> config_bits[$past(op_arg[CFG_IDX_W-1:0])];
    endproperty
    a_cfg_set: assert property (p_cfg_set) else $error("config bit not set");

    property p_cfg_clr;
        op_done && op_code == CODE_CLR_CFG && cfg_ok |=> !config_bits[$past(op_arg[CFG_IDX_W-1:0])];
    endproperty
    a_cfg_clr: assert property (p_cfg_clr) else $error("config bit not cleared");

    property p_cfg_oob;
        op_done && !cfg_ok && (op_code == CODE_SET_CFG || op_code == CODE_CLR_CFG)
            |=> $stable(config_bits);
    endproperty
    a_cfg_oob: assert property (p_cfg_oob) else $error("out-of-range config changed");

    c_clr_lock: cover property (op_done && op_code == CODE_CLR_LOCK && region_ok);
    c_bad_key:  cover property (cmd_bad);
    c_two_pops: cover property (pop_result && res_sel == RES_LOCK ##[1:20] pop_result);
    c_irq:      cover property ($rose(irq));

endmodule

`default_nettype wire

// file: core/fls_pkg.sv
// Shared constants and types for the flash lock and configuration-bit sequencer
package fls_pkg;

    // Register map, byte addresses on the AXI4-Lite slave
    localparam int         ADDR_W         = 8;
    localparam int         DATA_W         = 32;
    localparam logic [7:0] OFF_MODE       = 8'h00;
    localparam logic [7:0] OFF_CMD        = 8'h04;
    localparam logic [7:0] OFF_STATUS     = 8'h08;
    localparam logic [7:0] OFF_RESULT     = 8'h0C;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
    localparam logic [3:0] STRB_ALL       = 4'hF;
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;

    // Lock regions and configuration bits
    localparam int         NUM_LOCK_BITS  = 64;
    localparam int         LOCK_IDX_W     = 6;
    localparam int         LOCK_WORDS     = NUM_LOCK_BITS / DATA_W;
    localparam int         REGION_SHIFT   = 4;
    localparam int         NUM_CFG_BITS   = 3;
    localparam int         CFG_IDX_W      = 2;
    localparam int         IDX_W          = 3;
    localparam logic [NUM_LOCK_BITS-1:0] LOCK_RESET = '0;
    localparam logic [NUM_CFG_BITS-1:0]  CFG_RESET  = '0;

    // Command word: keyword, argument, opcode
    localparam logic [7:0] CMD_KEY        = 8'hA5;
    localparam logic [7:0] CODE_CLR_LOCK  = 8'h01;
    localparam logic [7:0] CODE_GET_LOCK  = 8'h02;
    localparam logic [7:0] CODE_SET_CFG   = 8'h03;
    localparam logic [7:0] CODE_CLR_CFG   = 8'h04;
    localparam logic [7:0] CODE_GET_CFG   = 8'h05;
    localparam logic [7:0] CODE_SET_LOCK  = 8'h06;

    // Operation time of one command, rounded up to whole cycles
    localparam int         CLK_PERIOD_PS  = 5000;
    localparam int         OP_TIME_NS     = 100;
    localparam int         OP_CYCLES      = (OP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int         CNT_W          = 8;

    typedef struct packed {
        logic [7:0]  key;
        logic [15:0] arg;
        logic [7:0]  code;
    } fls_cmd_t;

    // Event layout shared by irq status and mode (mask) registers
    typedef struct packed {
        logic err;
        logic done;
    } fls_ev_t;

    localparam int EV_W = 2;

    typedef enum {ST_IDLE, ST_RUN} fls_state_t;
    typedef enum {RES_NONE, RES_LOCK, RES_CFG} fls_res_t;

endpackage

// file: dv/fls_tb.sv
// Self-checking testbench for the lock and configuration-bit command sequencer
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import fls_pkg::*;

    logic                     aclk;
    logic                     aresetn;
    logic [ADDR_W-1:0]        awaddr;
    logic                     awvalid;
    logic                     awready;
    logic [DATA_W-1:0]        wdata;
    logic [3:0]               wstrb;
    logic                     wvalid;
    logic                     wready;
    logic [1:0]               bresp;
    logic                     bvalid;
    logic [ADDR_W-1:0]        araddr;
    logic                     arvalid;
    logic                     arready;
    logic [DATA_W-1:0]        rdata;
    logic [1:0]               rresp;
    logic                     rvalid;
    logic                     irq;
    logic                     prog_req;
    logic [15:0]              prog_page;
    logic                     prog_grant;
    logic                     array_read_enable;
    logic [NUM_LOCK_BITS-1:0] lock_state;
    logic [NUM_CFG_BITS-1:0]  config_bits;
    logic [31:0]              rd;
    logic [1:0]               rsp;
    int                       errors;
    int                       checks;
    int                       cyc = 0;

    // Ready lines are held high: the master always accepts answers at once
    fls_lock_nvm_seq DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(1'b1), .araddr(araddr),
        .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(1'b1), .irq(irq), .prog_req(prog_req),
        .prog_page(prog_page), .prog_grant(prog_grant),
        .array_read_enable(array_read_enable), .lock_state(lock_state),
        .config_bits(config_bits));

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Watchdog sized well above the whole sequence of commands
    localparam int TIMEOUT_CYCLES = 20000;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= STRB_ALL;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        rsp = bresp;
    endtask

    task automatic rdr(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rd = rdata;
        rsp = rresp;
    endtask

    task automatic cmd(input logic [7:0] code, input logic [15:0] arg);
        wr(OFF_CMD, {CMD_KEY, arg, code});
    endtask

    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            rdr(OFF_STATUS);
            n++;
        end while (rd[0] !== 1'b1 && n < 40);
        chk(rd[1:0], 2'h1);
    endtask

    task automatic t_reset;
        rdr(OFF_STATUS);
        chk(rd, 32'h1);
        rdr(OFF_MODE);
        chk(rd, 32'h0);
        rdr(OFF_RESULT);
        chk(rd, 32'h0);
        rdr(8'h14);
        chk(rsp, RESP_SLVERR);
        chk(rd, 32'h0);
        chk(lock_state, LOCK_RESET);
        $display("test reset done");
    endtask

    task automatic t_clear_lock;
        wr(OFF_MODE, 32'h3);
        chk(rsp, RESP_OKAY);
        cmd(CODE_SET_LOCK, 16'd80);
        wait_ready();
        cmd(CODE_SET_LOCK, 16'd655);
        wait_ready();
        chk(lock_state, (64'h1 << 5) | (64'h1 << 40));
        @(posedge aclk);
        prog_req <= 1'b1;
        prog_page <= 16'd83;
        @(negedge aclk);
        chk(prog_grant, 1'b0);
        wr(OFF_IRQ_STATUS, 32'h3);
        cmd(CODE_CLR_LOCK, 16'd83);
        @(negedge aclk);
        chk(array_read_enable, 1'b1);
        chk(irq, 1'b0);
        rdr(OFF_STATUS);
        chk(rd[0], 1'b0);
        wait_ready();
        @(negedge aclk);
        chk(irq, 1'b1);
        chk(lock_state, 64'h1 << 40);
        chk(prog_grant, 1'b1);
        @(posedge aclk);
        prog_page <= 16'd645;
        @(negedge aclk);
        chk(prog_grant, 1'b0);
        cmd(CODE_CLR_LOCK, 16'd1024);
        wait_ready();
        cmd(CODE_CLR_LOCK, 16'hFFFF);
        wait_ready();
        chk(lock_state, 64'h1 << 40);
        $display("test clear lock done");
    endtask

    task automatic t_get_lock;
        cmd(CODE_SET_LOCK, 16'd35);
        wait_ready();
        cmd(CODE_GET_LOCK, 16'hBEEF);
        wait_ready();
        rdr(OFF_RESULT);
        chk(rd, 32'h4);
        chk(rsp, RESP_OKAY);
        rdr(OFF_RESULT);
        chk(rd, 32'h100);
        rdr(OFF_RESULT);
        chk(rd, 32'h0);
        $display("test get lock done");
    endtask

    task automatic t_bad_key;
        wr(OFF_IRQ_STATUS, 32'h3);
        wr(OFF_CMD, {8'h5A, 16'd35, CODE_CLR_LOCK});
        rdr(OFF_STATUS);
        chk(rd, 32'h3);
        rdr(OFF_IRQ_STATUS);
        chk(rd, 32'h2);
        chk(lock_state, (64'h1 << 40) | (64'h1 << 2));
        chk(irq, 1'b1);
        wr(OFF_IRQ_STATUS, 32'h3);
        @(negedge aclk);
        chk(irq, 1'b0);
        $display("test bad key done");
    endtask

    task automatic t_config;
        cmd(CODE_SET_CFG, 16'd2);
        wait_ready();
        @(negedge aclk);
        chk(config_bits, 3'h4);
        chk(irq, 1'b1);
        chk(lock_state, (64'h1 << 40) | (64'h1 << 2));
        cmd(CODE_SET_CFG, 16'd3);
        wait_ready();
        chk(config_bits, 3'h4);
        cmd(CODE_GET_CFG, 16'd0);
        wait_ready();
        rdr(OFF_RESULT);
        chk(rd, 32'h4);
        rdr(OFF_RESULT);
        chk(rd, 32'h0);
        wr(OFF_IRQ_STATUS, 32'h3);
        cmd(CODE_CLR_CFG, 16'd2);
        wait_ready();
        @(negedge aclk);
        chk(config_bits, 3'h0);
        chk(irq, 1'b1);
        wr(OFF_MODE, 32'h0);
        @(negedge aclk);
        chk(irq, 1'b0);
        $display("test config done");
    endtask

    // Reset in the middle of an operation must abandon it and clear all state
    task automatic t_mid_reset;
        cmd(CODE_SET_LOCK, 16'd16);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk(lock_state, LOCK_RESET);
        rdr(OFF_STATUS);
        chk(rd, 32'h1);
        cmd(CODE_SET_CFG, 16'd0);
        wait_ready();
        chk(config_bits, 3'h1);
        chk(irq, 1'b0);
        $display("test mid reset done");
    endtask

    initial begin
        errors = 0;
        checks = 0;
        aresetn = 1'b0;
        awaddr = '0;
        awvalid = 1'b0;
        wdata = '0;
        wstrb = '0;
        wvalid = 1'b0;
        araddr = '0;
        arvalid = 1'b0;
        prog_req = 1'b0;
        prog_page = '0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        fork
            begin
                t_reset();
                t_clear_lock();
                t_get_lock();
                t_bad_key();
                t_config();
                t_mid_reset();
            end
            begin
                wait (cyc == TIMEOUT_CYCLES);
                errors++;
            end
        join_any
        disable fork;
        report_and_stop();
    end
endmodule

`default_nettype wire
